// file: bench/ovss_host_model.sv
// ovss_host_model: host pull-up resistor on the power-good pin
`timescale 1ns/10ps
module ovss_host_model (
	input  wire logic pg_o_in,   // pin data from the device
	input  wire logic pg_oe_in,  // pin pull-low enable
	output logic      pg_pin_out // level the host reads
);
	// a released pin is pulled up, so the host sees it high
	assign pg_pin_out = pg_oe_in ? pg_o_in : 1'h1;
endmodule : ovss_host_model

// file: bench/ovss_properties.sv
// ovss_properties: port timing checks for the switch sequencer
`timescale 1ns/10ps
module ovss_properties #(
	parameter int unsigned DEBOUNCE_CYC = 20, // startup debounce
	parameter int unsigned RETRY_CYC    = 20  // autoretry wait
) (
	input wire logic                  sys_clk_in,          // clock
	input wire logic                  reset_n_in,          // reset, low
	input wire ovss_pkg::ovss_sense_t sense_in,            // indications
	input wire logic                  switch_en_n_in,      // enable, low
	input wire logic                  pump_en_out,         // pump
	input wire logic                  osc_run_out,         // oscillator
	input wire logic                  switch_on_out,       // switch
	input wire logic                  power_good_n_o_out,  // pin data
	input wire logic                  power_good_n_oe_out, // pin pull-low
	input wire logic                  fault_out            // fault
);
	// short names for the indications
	wire bad = sense_in.low_input_lockout | sense_in.high_input_lockout;
	wire oc  = sense_in.overcurrent;
	wire hot = sense_in.thermal_trip;
	wire clr = sense_in.thermal_clear;
	int  on_run;
	int  off_run;
	// run lengths: long counts cannot be unrolled as repetitions
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			on_run  <= 0;
			off_run <= 0;
		end else begin
			on_run  <= pump_en_out ? on_run + 1 : 0;
			off_run <= switch_on_out ? 0 : off_run + 1;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	pump_start_a: assert property ((!bad && !hot && clr)[*7] |-> pump_en_out && osc_run_out)
		else $error("pump not running in valid range");
	dropout_a: assert property (bad[*5] |-> !pump_en_out && !osc_run_out &&
		!power_good_n_oe_out && !switch_on_out) else $error("no dropout out of range");
	open_drain_a: assert property (power_good_n_o_out == 1'h0)
		else $error("power good driven high");
	debounce_full_a: assert property ($rose(power_good_n_oe_out) |->
		on_run >= DEBOUNCE_CYC && on_run <= DEBOUNCE_CYC + 4) else $error("debounce length");
	oc_cutoff_a: assert property (oc[*8] |-> !switch_on_out || fault_out)
		else $error("switch left on in overcurrent");
	retry_wait_a: assert property ($rose(switch_on_out) && fault_out |->
		off_run >= RETRY_CYC && off_run <= RETRY_CYC + 4) else $error("retry length");
	retry_again_a: assert property ($rose(switch_on_out) && fault_out ##1 oc[*8] |->
		fault_out && !switch_on_out) else $error("no second turn-off");
	retry_end_a: assert property ($rose(switch_on_out) && fault_out ##1
		(!oc && !bad && !hot && !switch_en_n_in)[*8] |-> !fault_out && switch_on_out)
		else $error("retry did not end");
	enable_gate_a: assert property (switch_en_n_in[*5] |-> !switch_on_out)
		else $error("switch on while disabled");
	thermal_off_a: assert property (hot[*5] |-> fault_out && !switch_on_out)
		else $error("thermal trip ignored");
	thermal_hold_a: assert property ($fell(hot) ##1 (!clr)[*6] |-> fault_out)
		else $error("thermal left before cooling");
endmodule : ovss_properties

bind ovss_top ovss_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RETRY_CYC(RETRY_CYC)) chk (
	.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .sense_in(sense_in),
	.switch_en_n_in(switch_en_n_in), .pump_en_out(pump_en_out), .osc_run_out(osc_run_out),
	.switch_on_out(switch_on_out), .power_good_n_o_out(power_good_n_o_out),
	.power_good_n_oe_out(power_good_n_oe_out), .fault_out(fault_out));

// file: bench/testbench.sv
// testbench: self-checking bench for the switch sequencer
`timescale 1ns/10ps
module testbench;
	localparam int DEB = 20; // shortened debounce
	localparam int RET = 20; // shortened retry
	typedef struct {
		ovss_pkg::ovss_sense_t v;
		logic                  e;
		logic [3:0]            x; // pump, switch, pg enable, fault
	} ovss_row_t;
	logic                  clk = 1'h0;
	logic                  rst_n = 1'h0;
	ovss_pkg::ovss_sense_t s = 5'h01;
	logic                  en_n = 1'h0;
	logic                  pump, osc, sw, pg_o, pg_oe, flt, pin;
	int                    errors = 0;
	int                    total_checks = 0;
	int                    cyc = 0;
	ovss_row_t             rows [5] = '{'{5'h11, 1'h0, 4'h0}, '{5'h01, 1'h0, 4'hE},
		'{5'h01, 1'h1, 4'hA}, '{5'h09, 1'h0, 4'h0}, '{5'h01, 1'h0, 4'hE}};

	ovss_top #(.DEBOUNCE_CYC(DEB), .RETRY_CYC(RET), .BLANK_CYC(5), .OC_OFF_CYC(3)) dut (
		.sys_clk_in(clk), .reset_n_in(rst_n), .sense_in(s), .switch_en_n_in(en_n),
		.pump_en_out(pump), .osc_run_out(osc), .switch_on_out(sw),
		.power_good_n_o_out(pg_o), .power_good_n_oe_out(pg_oe), .fault_out(flt));
	ovss_host_model host (.pg_o_in(pg_o), .pg_oe_in(pg_oe), .pg_pin_out(pin));

	// clock and hang guard; a stuck run still reaches the report
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors = errors + 1;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic x, input logic g);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("unexpected %s: expected %b, seen %b", n, x, g);
		end
	endtask : chk

	task automatic chk4(input logic [3:0] x);
		chk("pump", x[3], pump);
		chk("oscillator", x[3], osc);
		chk("switch", x[2], sw);
		chk("pin", !x[1], pin);
		chk("fault", x[0], flt);
	endtask : chk4

	// inputs change on the falling edge, away from sampling
	task automatic step(input ovss_pkg::ovss_sense_t v, input logic e, input int n);
		@(negedge clk);
		s = v;
		en_n = e;
		repeat (n) @(negedge clk);
	endtask : step

	task automatic end_of_test();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'h1;
		foreach (rows[i]) begin
			step(rows[i].v, rows[i].e, DEB + 10);
			chk4(rows[i].x);
		end
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		chk4(4'h0);
		rst_n = 1'h1;
		// a brief dropout must restart the whole debounce
		step(5'h01, 1'h0, 15);
		step(5'h11, 1'h0, 4);
		step(5'h01, 1'h0, 15);
		chk4(4'h8);
		repeat (12) @(negedge clk);
		chk4(4'hE);
		step(5'h05, 1'h0, 8);
		chk4(4'hB);
		step(5'h05, 1'h0, 30);
		step(5'h01, 1'h0, RET + 20);
		chk4(4'hE);
		step(5'h03, 1'h0, 6);
		chk("switch", 1'h0, sw);
		chk("fault", 1'h1, flt);
		step(5'h00, 1'h0, 10);
		chk("fault", 1'h1, flt);
		step(5'h01, 1'h0, DEB + 10);
		chk4(4'hE);
		end_of_test();
	end
endmodule : testbench

// file: rtl/ovss_pkg.sv
// ovss_pkg: shared constants and types for the overvoltage switch sequencer
package ovss_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned DEBOUNCE_MS     = 30;     // debounce_interval
	localparam int unsigned RETRY_MS        = 30;     // autoretry interval
	localparam int unsigned BLANK_US        = 10;     // overcurrent blanking
	localparam int unsigned OC_OFF_US       = 5;      // overcurrent turn-off
	localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned RETRY_CYC       = (CLK_HZ / 1000) * RETRY_MS;
	localparam int unsigned BLANK_CYC       = (CLK_HZ / 1_000_000) * BLANK_US;
	localparam int unsigned OC_OFF_CYC      = (CLK_HZ / 1_000_000) * OC_OFF_US;
	localparam int unsigned CNT_W           = 24;

	// ------------------------------------------------------------
	// indication levels kept for reference (millivolts, deg C)
	// ------------------------------------------------------------
	localparam int unsigned LOW_LOCKOUT_MV  = 2550;
	localparam int unsigned HIGH_LOCKOUT_MV = 6150;
	localparam int unsigned THERMAL_HYST_C  = 40;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OVSS_ST_OFF      = 3'b000,
		OVSS_ST_DEBOUNCE = 3'b001,
		OVSS_ST_ON       = 3'b010,
		OVSS_ST_BLANK    = 3'b011,
		OVSS_ST_RETRY    = 3'b100,
		OVSS_ST_THERMAL  = 3'b101
	} ovss_state_t;

	typedef struct packed {
		logic low_input_lockout;   // input below low lockout level
		logic high_input_lockout;  // input above high lockout level
		logic overcurrent;         // current limit tripped
		logic thermal_trip;        // junction above thermal_trip_level
		logic thermal_clear;       // junction cooled by the hysteresis
	} ovss_sense_t;

endpackage : ovss_pkg

// file: rtl/ovss_sync.sv
// ovss_sync: two flip-flop synchroniser for a group of sense levels
`timescale 1ns/10ps
module ovss_sync #(
	parameter int unsigned WIDTH = 5
) (
	input  wire logic             sys_clk_in,   // system clock
	input  wire logic             reset_n_in,   // async reset, active low
	input  wire logic [WIDTH-1:0] async_in,     // raw levels from pins
	output logic      [WIDTH-1:0] sync_out      // levels in clock domain
);

	// ------------------------------------------------------------
	// synchroniser chain
	// ------------------------------------------------------------
	logic [WIDTH-1:0] meta;

	// first stage is read only by the second stage
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule : ovss_sync

// file: rtl/ovss_timer.sv
// ovss_timer: down-counting interval timer with one-cycle done pulse
`timescale 1ns/10ps
module ovss_timer #(
	parameter int unsigned CNT_W = 24
) (
	input  wire logic             sys_clk_in,   // system clock
	input  wire logic             reset_n_in,   // async reset, active low
	input  wire logic             start_in,     // load and run
	input  wire logic             stop_in,      // abandon count
	input  wire logic [CNT_W-1:0] load_in,      // cycles to count
	output logic                  done_out      // pulse on expiry
);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	logic [CNT_W-1:0] count;
	logic             running;
	wire              last = running && (count == {{(CNT_W-1){1'b0}}, 1'b1});

	// stop wins over start so a dropout mid-cycle never leaves a stale count
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count    <= '0;
			running  <= 1'b0;
			done_out <= 1'b0;
		end else if (stop_in) begin
			running  <= 1'b0;
			done_out <= 1'b0;
		end else if (start_in) begin
			count    <= load_in;
			running  <= 1'b1;
			done_out <= 1'b0;
		end else begin
			done_out <= last;
			if (last)
				running <= 1'b0;
			if (running)
				count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule : ovss_timer

// file: rtl/ovss_top.sv
// ovss_top: sequencer for the overvoltage protection switch
`timescale 1ns/10ps
module ovss_top #(
	parameter int unsigned DEBOUNCE_CYC = ovss_pkg::DEBOUNCE_CYC, // startup debounce
	parameter int unsigned RETRY_CYC    = ovss_pkg::RETRY_CYC,    // autoretry wait
	parameter int unsigned BLANK_CYC    = ovss_pkg::BLANK_CYC,    // overcurrent blanking
	parameter int unsigned OC_OFF_CYC   = ovss_pkg::OC_OFF_CYC    // fast trip response
) (
	input  wire logic               sys_clk_in,        // free-running clock, 50 MHz
	input  wire logic               reset_n_in,        // async reset, active low
	input  wire ovss_pkg::ovss_sense_t sense_in,       // raw analog indications
	input  wire logic               switch_en_n_in,    // switch enable, active low
	output logic                    pump_en_out,       // charge pump enable
	output logic                    osc_run_out,       // timing oscillator running
	output logic                    switch_on_out,     // pass switch gate drive
	output logic                    power_good_n_o_out, // power_good_n output level, always 0
	output logic                    power_good_n_oe_out, // power_good_n pull-low enable
	output logic                    fault_out          // overcurrent or thermal fault
);

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	localparam int unsigned NSYNC = $bits(ovss_pkg::ovss_sense_t) + 1;
	localparam int unsigned CW    = ovss_pkg::CNT_W;

	logic [NSYNC-1:0]      sync_bus;
	ovss_pkg::ovss_sense_t sense;
	logic                  en_n;

	ovss_sync #(.WIDTH(NSYNC)) u_sync (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({switch_en_n_in, sense_in}),
		.sync_out   (sync_bus)
	);

	assign sense = ovss_pkg::ovss_sense_t'(sync_bus[NSYNC-2:0]);
	assign en_n  = sync_bus[NSYNC-1];

	// the sync stages hold zeros just after reset, which would read as a valid
	// range and start a false debounce; ignore them until real samples arrive
	logic [1:0] sync_warm;

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_warm <= 2'h0;
		end else begin
			sync_warm <= {sync_warm[0], 1'b1};
		end
	end

	// ------------------------------------------------------------
	// decoded conditions
	// ------------------------------------------------------------
	wire in_range  = sync_warm[1] &&
	                 !sense.low_input_lockout && !sense.high_input_lockout;
	wire out_range = !in_range;
	wire oc        = sense.overcurrent;
	wire hot       = sense.thermal_trip;
	wire cooled    = sense.thermal_clear;

	// ------------------------------------------------------------
	// state register and timer
	// ------------------------------------------------------------
	ovss_pkg::ovss_state_t state;
	ovss_pkg::ovss_state_t next_state;
	logic                  tmr_start;
	logic                  tmr_stop;
	logic [CW-1:0]         tmr_load;
	logic                  tmr_done;
	logic [CW-1:0]         oc_cnt;
	logic [CW-1:0]         next_oc_cnt;

	// one timer serves debounce, blanking and retry since they never overlap
	ovss_timer #(.CNT_W(CW)) u_timer (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.start_in   (tmr_start),
		.stop_in    (tmr_stop),
		.load_in    (tmr_load),
		.done_out   (tmr_done)
	);

	// state transitions; thermal trip takes priority over all, then range dropout outside THERMAL
	always_comb begin
		next_state = state;
		tmr_start  = 1'b0;
		tmr_stop   = 1'b0;
		tmr_load   = CW'(DEBOUNCE_CYC);
		case (state)
			ovss_pkg::OVSS_ST_OFF: begin
				if (in_range && !hot) begin
					next_state = ovss_pkg::OVSS_ST_DEBOUNCE;
					tmr_start  = 1'b1;
				end
			end
			ovss_pkg::OVSS_ST_DEBOUNCE: begin
				if (tmr_done)
					next_state = ovss_pkg::OVSS_ST_ON;
			end
			ovss_pkg::OVSS_ST_ON: begin
				if (oc && !en_n && oc_cnt >= CW'(OC_OFF_CYC - 1)) begin
					next_state = ovss_pkg::OVSS_ST_RETRY;
					tmr_start  = 1'b1;
					tmr_load   = CW'(RETRY_CYC);
				end
			end
			ovss_pkg::OVSS_ST_RETRY: begin
				if (tmr_done) begin
					next_state = ovss_pkg::OVSS_ST_BLANK;
					tmr_start  = 1'b1;
					tmr_load   = CW'(BLANK_CYC);
				end
			end
			ovss_pkg::OVSS_ST_BLANK: begin
				if (tmr_done) begin
					if (oc) begin
						next_state = ovss_pkg::OVSS_ST_RETRY;
						tmr_start  = 1'b1;
						tmr_load   = CW'(RETRY_CYC);
					end else begin
						next_state = ovss_pkg::OVSS_ST_ON;
					end
				end
			end
			ovss_pkg::OVSS_ST_THERMAL: begin
				if (cooled && !hot)
					next_state = ovss_pkg::OVSS_ST_OFF;
			end
			default: next_state = ovss_pkg::OVSS_ST_OFF;
		endcase
		if (hot && state != ovss_pkg::OVSS_ST_THERMAL) begin
			next_state = ovss_pkg::OVSS_ST_THERMAL;
			tmr_start  = 1'b0;
			tmr_stop   = 1'b1;
		end else if (out_range && state != ovss_pkg::OVSS_ST_THERMAL) begin
			next_state = ovss_pkg::OVSS_ST_OFF;
			tmr_start  = 1'b0;
			tmr_stop   = 1'b1;
		end
	end

	// overcurrent persistence while on gives the fast trip filter
	always_comb begin
		if (state == ovss_pkg::OVSS_ST_ON && oc && !en_n)
			next_oc_cnt = oc_cnt + {{(CW-1){1'b0}}, 1'b1};
		else
			next_oc_cnt = '0;
	end

	// ------------------------------------------------------------
	// output decode
	// ------------------------------------------------------------
	wire on_state  = (next_state == ovss_pkg::OVSS_ST_ON) ||
	                 (next_state == ovss_pkg::OVSS_ST_BLANK);
	wire next_sw   = on_state && !en_n;
	wire next_pump = in_range && !hot &&
	                 (next_state != ovss_pkg::OVSS_ST_OFF) &&
	                 (next_state != ovss_pkg::OVSS_ST_THERMAL);
	wire next_pg   = in_range && (next_state != ovss_pkg::OVSS_ST_OFF) &&
	                 (next_state != ovss_pkg::OVSS_ST_DEBOUNCE) &&
	                 (next_state != ovss_pkg::OVSS_ST_THERMAL);
	wire next_flt  = (next_state == ovss_pkg::OVSS_ST_RETRY) ||
	                 (next_state == ovss_pkg::OVSS_ST_BLANK) ||
	                 (next_state == ovss_pkg::OVSS_ST_THERMAL);

	// registered outputs so every pin is a flip-flop
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state               <= ovss_pkg::OVSS_ST_OFF;
			oc_cnt              <= '0;
			pump_en_out         <= 1'b0;
			osc_run_out         <= 1'b0;
			switch_on_out       <= 1'b0;
			power_good_n_o_out  <= 1'b0;
			power_good_n_oe_out <= 1'b0;
			fault_out           <= 1'b0;
		end else begin
			state               <= next_state;
			oc_cnt              <= next_oc_cnt;
			pump_en_out         <= next_pump;
			osc_run_out         <= next_pump;
			switch_on_out       <= next_sw;
			power_good_n_o_out  <= 1'b0;
			power_good_n_oe_out <= next_pg;
			fault_out           <= next_flt;
		end
	end

endmodule : ovss_top
